// ==== hdl/rsf_pkg.sv ====
/*
 * constants, enumerations and the state record of the cpu register set
 * assumes one core clock; all users import the whole package
 */
`default_nettype none
package rsf_pkg;
    // reset values and fixed addresses
    localparam logic [15:0] RSF_SP_RESET   = 16'h00ff;
    localparam logic [7:0]  RSF_H_RESET    = 8'h00;
    localparam logic [15:0] RSF_VEC_RESET  = 16'hfffe;
    localparam logic [15:0] RSF_PC_RESET   = 16'h0000;
    localparam logic [7:0]  RSF_CCR_ONES   = 8'h60;
    localparam logic [7:0]  RSF_CCR_RESET  = 8'h68;
    localparam logic [7:0]  RSF_PAGE0_HI   = 8'h00;
    localparam logic [7:0]  RSF_SP_LOW_RLD = 8'hff;
    // condition flag bit positions
    localparam int RSF_V = 7;
    localparam int RSF_H = 4;
    localparam int RSF_I = 3;
    localparam int RSF_N = 2;
    localparam int RSF_Z = 1;
    localparam int RSF_C = 0;
    // sequence lengths: five stacked bytes, three queue fills
    localparam logic [2:0] RSF_PUSH_LAST = 3'h4;
    localparam logic [2:0] RSF_FILL_LAST = 3'h2;
    localparam int         RSF_BOOT_CYC  = 6;
    // decimal adjust thresholds and corrections
    localparam logic [7:0] RSF_DAA_HI_LIM = 8'h99;
    localparam logic [3:0] RSF_DAA_LO_LIM = 4'h9;
    localparam logic [3:0] RSF_DAA_CORR   = 4'h6;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_ORA, ALU_EOR,
        ALU_PASS, ALU_LSL, ALU_LSR, ALU_ROL, ALU_ROR, ALU_DAA
    } rsf_alu_op_t;

    typedef enum logic [1:0] {DST_NONE, DST_A, DST_X} rsf_dst_t;

    typedef enum logic [3:0] {
        ROP_NONE, ROP_LD_HX, ROP_TAP, ROP_TPA, ROP_CLI, ROP_SEI,
        ROP_AIS, ROP_RSP, ROP_TAX, ROP_TXA
    } rsf_reg_op_t;

    typedef enum logic [2:0] {
        AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2, AM_SP1, AM_SP2
    } rsf_mode_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_PUSH, ST_VEC_HI, ST_VEC_LO, ST_FREE, ST_FILL
    } rsf_state_t;

    typedef struct packed {
        rsf_state_t  state;
        logic [2:0]  cnt;
        logic [7:0]  acc;
        logic [7:0]  xl;
        logic [7:0]  hi;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0]  condition_flags;
        logic        inhibit;
        logic [15:0] vec;
        logic [15:0] ea;
        logic [15:0] mem_addr;
        logic        mem_rd;
        logic        mem_wr;
        logic [7:0]  mem_wdata;
    } rsf_st_t;
endpackage
`default_nettype wire

// ==== hdl/rsf_alu.sv ====
/*
 * 8-bit result and condition flag generator
 * assumes the caller registers result and flags; purely combinational
 */
`default_nettype none
module rsf_alu
    import rsf_pkg::*;
(
    input  wire rsf_alu_op_t op,      // operation select
    input  wire logic [7:0]  a,       // left operand
    input  wire logic [7:0]  b,       // right operand
    input  wire logic [7:0]  ccr_in,  // flags before the operation
    output logic [7:0]       res,     // result byte
    output logic [7:0]       ccr_out  // flags after the operation
);
    logic [8:0] wide;
    logic       cy;
    logic [7:0] corr;

    // one case per operation or group of operations, flags common to all at the end
    always_comb
    begin
        wide = 9'h000;
        corr = 8'h00;
        cy = ccr_in[RSF_C];
        res = a;
        ccr_out = ccr_in;
        case (op)
            ALU_ADD, ALU_ADC:
            begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, (op == ALU_ADC) & cy};
                res = wide[7:0];
                ccr_out[RSF_H] = a[4] ^ b[4] ^ res[4];
                ccr_out[RSF_V] = (a[7] == b[7]) && (res[7] != a[7]);
                ccr_out[RSF_C] = wide[8];
            end
            ALU_SUB, ALU_SBC:
            begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, (op == ALU_SBC) & cy};
                res = wide[7:0];
                ccr_out[RSF_V] = (a[7] != b[7]) && (res[7] != a[7]);
                ccr_out[RSF_C] = wide[8];
            end
            ALU_AND:  begin res = a & b; ccr_out[RSF_V] = 1'b0; end
            ALU_ORA:  begin res = a | b; ccr_out[RSF_V] = 1'b0; end
            ALU_EOR:  begin res = a ^ b; ccr_out[RSF_V] = 1'b0; end
            ALU_PASS: begin res = b; ccr_out[RSF_V] = 1'b0; end
            ALU_LSL, ALU_ROL, ALU_LSR, ALU_ROR:
            begin
                // rotates pull the old carry in
                if (op == ALU_LSL || op == ALU_ROL)
                begin
                    res = {a[6:0], (op == ALU_ROL) & cy};
                    ccr_out[RSF_C] = a[7];
                end
                else
                begin
                    res = {(op == ALU_ROR) & cy, a[7:1]};
                    ccr_out[RSF_C] = a[0];
                end
                ccr_out[RSF_V] = res[7] ^ ccr_out[RSF_C];
            end
            ALU_DAA:
            begin
                // correction only meaningful right after a bcd add
                if (cy || a > RSF_DAA_HI_LIM)
                begin
                    corr[7:4] = RSF_DAA_CORR;
                    ccr_out[RSF_C] = 1'b1;
                end
                if (ccr_in[RSF_H] || a[3:0] > RSF_DAA_LO_LIM)
                    corr[3:0] = RSF_DAA_CORR;
                res = a + corr;
            end
            default: res = a;
        endcase
        ccr_out[RSF_N] = res[7];
        ccr_out[RSF_Z] = (res == 8'h00);
        ccr_out = ccr_out | RSF_CCR_ONES;
    end
endmodule
`default_nettype wire

// ==== hdl/rsf_regs.sv ====
/*
 * programmer-visible register set of an 8-bit core: accumulator, index pair,
 * stack pointer, program counter, condition flags, reset-vector and
 * interrupt-entry sequencing, effective address forming
 * assumes the core's execution unit issues at most one register or alu
 * operation per cycle and owns the bus while busy is low; memory read data
 * is valid in the cycle mem_rd is high
 */
`default_nettype none
module rsf_regs
    import rsf_pkg::*;
(
    input  wire logic        clk,         // core clock
    input  wire logic        rstn,        // synchronous reset, active low
    input  wire logic        fetch,       // core took the byte at pc_q
    input  wire logic        flow_load,   // jump or return target valid
    input  wire logic [15:0] flow_target, // absolute target
    input  wire logic        flow_rel,    // taken relative branch
    input  wire logic [7:0]  rel_off,     // signed branch offset
    input  wire logic        inst_end,    // last cycle of an instruction
    input  wire logic        irq_req,     // maskable interrupt pending
    input  wire logic [15:0] irq_vec,     // vector address of that request
    input  wire logic        alu_go,      // perform alu_op this cycle
    input  wire rsf_alu_op_t alu_op,      // alu operation
    input  wire rsf_dst_t    alu_dst,     // where the result goes
    input  wire logic [7:0]  alu_b,       // memory or immediate operand
    input  wire rsf_reg_op_t reg_op,      // register operation
    input  wire logic [15:0] reg_imm,     // immediate for reg_op
    input  wire logic        agen_go,     // form an effective address
    input  wire rsf_mode_t   agen_mode,   // addressing mode
    input  wire logic [15:0] agen_off,    // offset or direct address
    input  wire logic        agen_inc,    // post-increment the index pair
    input  wire logic [7:0]  mem_rdata,   // bus read data
    output logic [15:0]      mem_addr,    // bus address during sequences
    output logic             mem_rd,      // bus read strobe
    output logic             mem_wr,      // bus write strobe
    output logic [7:0]       mem_wdata,   // bus write data
    output logic [7:0]       acc_q,       // accumulator
    output logic [15:0]      hx_q,        // index pair
    output logic [15:0]      sp_q,        // stack pointer
    output logic [15:0]      pc_q,        // program counter
    output logic [7:0]       ccr_q,       // condition flags
    output logic [15:0]      ea_q,        // effective address
    output logic             busy,        // sequence owns the bus
    output logic             signed_lt,   // signed less-than condition
    output logic             signed_gt    // signed greater-than condition
);
    rsf_st_t     st_reg;
    rsf_st_t     st_next;
    logic [7:0]  alu_res;
    logic [7:0]  alu_ccr;
    logic [15:0] hx;
    logic [15:0] ais_delta;
    logic        clear_now;
    logic        take;

    rsf_alu u_alu (
        .op      (alu_op),
        .a       ((alu_dst == DST_X) ? st_reg.xl : st_reg.acc),
        .b       (alu_b),
        .ccr_in  (st_reg.condition_flags),
        .res     (alu_res),
        .ccr_out (alu_ccr)
    );

    assign hx = {st_reg.hi, st_reg.xl};
    assign ais_delta = {{8{reg_imm[7]}}, reg_imm[7:0]};

    // next state: core operations while running, then the sequences
    always_comb
    begin
        st_next = st_reg;
        clear_now = 1'b0;
        take = 1'b0;
        st_next.mem_rd = 1'b0;
        st_next.mem_wr = 1'b0;
        case (st_reg.state)
            ST_RUN:
            begin
                if (flow_load)
                    st_next.pc = flow_target;
                else if (flow_rel)
                    st_next.pc = st_reg.pc + {{8{rel_off[7]}}, rel_off};
                else if (fetch)
                    st_next.pc = st_reg.pc + 16'h0001;
                if (alu_go)
                begin
                    if (alu_dst == DST_A)
                        st_next.acc = alu_res;
                    else if (alu_dst == DST_X)
                        st_next.xl = alu_res;
                    st_next.condition_flags = alu_ccr;
                end
                case (reg_op)
                    ROP_LD_HX:
                    begin
                        st_next.hi = reg_imm[15:8];
                        st_next.xl = reg_imm[7:0];
                        st_next.condition_flags[RSF_N] = reg_imm[15];
                        st_next.condition_flags[RSF_Z] = (reg_imm == 16'h0000);
                        st_next.condition_flags[RSF_V] = 1'b0;
                    end
                    ROP_TAP: st_next.condition_flags = st_reg.acc | RSF_CCR_ONES;
                    ROP_TPA: st_next.acc = st_reg.condition_flags;
                    ROP_CLI: st_next.condition_flags[RSF_I] = 1'b0;
                    ROP_SEI: st_next.condition_flags[RSF_I] = 1'b1;
                    ROP_AIS: st_next.sp = st_reg.sp + ais_delta;
                    ROP_RSP: st_next.sp[7:0] = RSF_SP_LOW_RLD;
                    ROP_TAX: st_next.xl = st_reg.acc;
                    ROP_TXA: st_next.acc = st_reg.xl;
                    default: st_next.condition_flags = st_next.condition_flags;
                endcase
                // address forming; direct page has an implied zero high byte
                if (agen_go)
                begin
                    case (agen_mode)
                        AM_DIR:  st_next.ea = {RSF_PAGE0_HI, agen_off[7:0]};
                        AM_EXT:  st_next.ea = agen_off;
                        AM_IX:   st_next.ea = hx;
                        AM_IX1:  st_next.ea = hx + {8'h00, agen_off[7:0]};
                        AM_IX2:  st_next.ea = hx + agen_off;
                        AM_SP1:  st_next.ea = st_reg.sp + {8'h00, agen_off[7:0]};
                        AM_SP2:  st_next.ea = st_reg.sp + agen_off;
                        default: st_next.ea = agen_off;
                    endcase
                    if (agen_inc)
                        {st_next.hi, st_next.xl} = hx + 16'h0001;
                end
                // a mask clear shadows the boundary that follows it
                clear_now = st_reg.condition_flags[RSF_I] && !st_next.condition_flags[RSF_I];
                if (clear_now && !inst_end)
                    st_next.inhibit = 1'b1;
                else if (inst_end)
                    st_next.inhibit = 1'b0;
                take = inst_end && irq_req && !st_next.condition_flags[RSF_I]
                       && !st_reg.inhibit && !clear_now;
                if (take)
                begin
                    st_next.state = ST_PUSH;
                    st_next.cnt = 3'h0;
                    st_next.vec = irq_vec;
                    st_next.mem_wr = 1'b1;
                    st_next.mem_addr = st_next.sp;
                    st_next.mem_wdata = st_next.pc[7:0];
                end
            end
            ST_PUSH:
            begin
                // write at sp, then step down to the next free byte
                st_next.sp = st_reg.sp - 16'h0001;
                st_next.cnt = st_reg.cnt + 3'h1;
                if (st_reg.cnt == RSF_PUSH_LAST)
                begin
                    st_next.condition_flags[RSF_I] = 1'b1;
                    st_next.state = ST_VEC_HI;
                    st_next.cnt = 3'h0;
                    st_next.mem_rd = 1'b1;
                    st_next.mem_addr = st_reg.vec;
                end
                else
                begin
                    st_next.mem_wr = 1'b1;
                    st_next.mem_addr = st_next.sp;
                    case (st_next.cnt)
                        3'h1:    st_next.mem_wdata = st_reg.pc[15:8];
                        3'h2:    st_next.mem_wdata = st_reg.xl;
                        3'h3:    st_next.mem_wdata = st_reg.acc;
                        default: st_next.mem_wdata = st_reg.condition_flags;
                    endcase
                end
            end
            ST_VEC_HI:
            begin
                st_next.pc[15:8] = mem_rdata;
                st_next.mem_rd = 1'b1;
                st_next.mem_addr = st_reg.vec + 16'h0001;
                st_next.state = ST_VEC_LO;
            end
            ST_VEC_LO:
            begin
                st_next.pc[7:0] = mem_rdata;
                st_next.state = ST_FREE;
            end
            ST_FREE:
            begin
                // one idle bus cycle, then the queue fill
                st_next.mem_rd = 1'b1;
                st_next.mem_addr = st_reg.pc;
                st_next.cnt = 3'h0;
                st_next.state = ST_FILL;
            end
            ST_FILL:
            begin
                st_next.pc = st_reg.pc + 16'h0001;
                st_next.cnt = st_reg.cnt + 3'h1;
                if (st_reg.cnt == RSF_FILL_LAST)
                    st_next.state = ST_RUN;
                else
                begin
                    st_next.mem_rd = 1'b1;
                    st_next.mem_addr = st_next.pc;
                end
            end
            default: st_next.state = ST_RUN;
        endcase
    end

    // accumulator and low index byte deliberately have no reset term
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_reg.state <= ST_VEC_HI;
            st_reg.cnt <= 3'h0;
            st_reg.hi <= RSF_H_RESET;
            st_reg.sp <= RSF_SP_RESET;
            st_reg.pc <= RSF_PC_RESET;
            st_reg.condition_flags <= RSF_CCR_RESET;
            st_reg.inhibit <= 1'b0;
            st_reg.vec <= RSF_VEC_RESET;
            st_reg.ea <= 16'h0000;
            st_reg.mem_addr <= RSF_VEC_RESET;
            st_reg.mem_rd <= 1'b1;
            st_reg.mem_wr <= 1'b0;
            st_reg.mem_wdata <= 8'h00;
        end
        else
            st_reg <= st_next;
    end

    // no register is decoded from the bus address; reached only by ports
    assign acc_q = st_reg.acc;
    assign hx_q = hx;
    assign sp_q = st_reg.sp;
    assign pc_q = st_reg.pc;
    assign ccr_q = st_reg.condition_flags | RSF_CCR_ONES;
    assign ea_q = st_reg.ea;
    assign mem_addr = st_reg.mem_addr;
    assign mem_rd = st_reg.mem_rd;
    assign mem_wr = st_reg.mem_wr;
    assign mem_wdata = st_reg.mem_wdata;
    assign busy = (st_reg.state != ST_RUN);
    assign signed_lt = st_reg.condition_flags[RSF_N] ^ st_reg.condition_flags[RSF_V];
    assign signed_gt = !(st_reg.condition_flags[RSF_Z] || signed_lt);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence boot_vec_s;
        mem_rd && mem_addr == RSF_VEC_RESET ##1 mem_rd && mem_addr == 16'hffff;
    endsequence
    sequence boot_fill_s;
        !mem_rd ##1 mem_rd [*3];
    endsequence

    boot_seq_a: assert property ($rose(rstn) |-> boot_vec_s ##1 boot_fill_s ##1 !busy)
        else $error("boot sequence not six cycles");
    boot_vec_a: assert property ($rose(rstn) |-> ##2 pc_q[15:8] == $past(mem_rdata, 2))
        else $error("vector high byte not from fffe");
    reset_val_a: assert property ($rose(rstn) |-> sp_q == RSF_SP_RESET && hx_q[15:8] == 8'h00)
        else $error("reset values of sp or h wrong");
    reset_keep_a: assert property ($rose(rstn) |-> $stable(acc_q) && $stable(hx_q[7:0]))
        else $error("reset disturbed a or x");
    flag_ones_a: assert property (st_reg.condition_flags[6:5] == 2'b11)
        else $error("fixed flag bits not one");
    mask_block_a: assert property (!busy && ccr_q[RSF_I] |=> st_reg.state != ST_PUSH)
        else $error("interrupt taken while masked");
    shadow_set_a: assert property (clear_now && !inst_end |=> st_reg.inhibit)
        else $error("mask clear did not arm shadow");
    shadow_hold_a: assert property (!busy && st_reg.inhibit && inst_end |=> !busy)
        else $error("interrupt taken in mask shadow");
    push_order_a: assert property (st_reg.state == ST_PUSH && st_reg.cnt == 3'h0 |->
        mem_wdata == pc_q[7:0] ##1 mem_wdata == pc_q[15:8] ##1 mem_wdata == hx_q[7:0]
        ##1 mem_wdata == acc_q ##1 mem_wdata == ccr_q)
        else $error("stacking order wrong");
    push_mask_a: assert property (st_reg.state == ST_PUSH && st_reg.cnt == 3'h0 |->
        (mem_wr && mem_addr == sp_q) [*5] ##1 ccr_q[RSF_I] && mem_rd && !mem_wr)
        else $error("mask not set after stacking");
    rsp_low_a: assert property (!busy && reg_op == ROP_RSP && !alu_go |=> sp_q == ($past(sp_q) | 16'h00ff))
        else $error("stack low reload touched high byte");
    ais_add_a: assert property (!busy && reg_op == ROP_AIS |=> sp_q == $past(sp_q) + $past(ais_delta))
        else $error("add to stack wrong");
    fetch_inc_a: assert property (!busy && fetch && !flow_load && !flow_rel |=> pc_q == $past(pc_q) + 16'h0001)
        else $error("pc did not advance on fetch");
    dir_page_a: assert property (!busy && agen_go && agen_mode == AM_DIR |=> ea_q[15:8] == 8'h00)
        else $error("direct address left page zero");
endmodule
`default_nettype wire

// ==== bench/rsf_mem.sv ====
/* partner memory for the register set: vectors, queue fill, stack writes
   assumes read data is wanted in the same cycle as mem_rd */
`default_nettype none
module rsf_mem (
    input  wire logic        clk,       // core clock
    input  wire logic [15:0] mem_addr,  // bus address
    input  wire logic        mem_rd,    // read strobe
    input  wire logic        mem_wr,    // write strobe
    input  wire logic [7:0]  mem_wdata, // write data
    output logic [7:0]       mem_rdata  // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] m [0:65535];
    logic [7:0] last = 8'h00;
    // background pattern so a queue fill never reads unknowns
    initial
    begin
        for (int i = 0; i < 65536; i++)
            m[i] = i[7:0] ^ 8'h5a;
    end
    // fixed vectors for reset and the one interrupt source
    function automatic logic [7:0] rd(input logic [15:0] a);
        case (a)
            16'hfffe: rd = 8'h12;
            16'hffff: rd = 8'h34;
            16'hfff0: rd = 8'h56;
            16'hfff1: rd = 8'h78;
            default:  rd = m[a];
        endcase
    endfunction
    // released bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_rd ? rd(mem_addr) : ~last;
    always @(posedge clk)
    begin
        if (mem_wr)
            m[mem_addr] <= mem_wdata;
        if (mem_rd)
            last <= rd(mem_addr);
    end
endmodule
`default_nettype wire

// ==== bench/rsf_regs_tb.sv ====
/* self-checking bench for the cpu register set
   assumes rsf_mem answers the bus; one operation per two cycles */
`default_nettype none
module rsf_regs_tb
    import rsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, fetch, flow_load, flow_rel, inst_end, irq_req, alu_go, agen_go, agen_inc;
    logic [15:0] flow_target, reg_imm, agen_off, mem_addr, hx_q, sp_q, pc_q, ea_q, irq_vec;
    logic [7:0]  rel_off, alu_b, mem_rdata, mem_wdata, acc_q, ccr_q;
    logic        mem_rd, mem_wr, busy, signed_lt, signed_gt;
    rsf_alu_op_t alu_op;
    rsf_dst_t    alu_dst;
    rsf_reg_op_t reg_op;
    rsf_mode_t   agen_mode;
    int          err_count, checked, n;
    int          cyc = 0;

    rsf_regs uut (
        .clk(clk), .rstn(rstn), .fetch(fetch), .flow_load(flow_load), .flow_target(flow_target),
        .flow_rel(flow_rel), .rel_off(rel_off), .inst_end(inst_end), .irq_req(irq_req), .irq_vec(irq_vec),
        .alu_go(alu_go), .alu_op(alu_op), .alu_dst(alu_dst), .alu_b(alu_b), .reg_op(reg_op),
        .reg_imm(reg_imm), .agen_go(agen_go), .agen_mode(agen_mode), .agen_off(agen_off),
        .agen_inc(agen_inc), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc_q(acc_q), .hx_q(hx_q), .sp_q(sp_q), .pc_q(pc_q),
        .ccr_q(ccr_q), .ea_q(ea_q), .busy(busy), .signed_lt(signed_lt), .signed_gt(signed_gt)
    );
    rsf_mem pm (
        .clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // s = {irq, fetch, load, rel, end, alu, agen}; strobes drop next edge, irq stays
    task automatic op(input logic [6:0] s, input rsf_reg_op_t r, input logic [15:0] v,
                      input rsf_alu_op_t ao = ALU_ADD, input rsf_mode_t m = AM_DIR,
                      input logic inc = 1'b0, input rsf_dst_t d = DST_A);
        @(posedge clk);
        {irq_req, fetch, flow_load, flow_rel, inst_end, alu_go, agen_go} <= s;
        reg_op      <= r;
        flow_target <= v;
        rel_off     <= v[7:0];
        alu_b       <= v[7:0];
        reg_imm     <= v;
        agen_off    <= v;
        alu_op      <= ao;
        agen_mode   <= m;
        agen_inc    <= inc;
        alu_dst     <= d;
        if (s[5:0] != 6'h00 || r != ROP_NONE)
            op(s & 7'h40, ROP_NONE, v, ao, m);
        #1;
    endtask

    // bounded wait; n keeps the busy length
    task automatic idle;
        n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task automatic rst;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(sp_q, 16'h00ff);
        chk(hx_q[15:8], 16'h0000);
        chk(ccr_q[6:5], 16'h0003);
        idle;
        chk(n[15:0], 16'h0006);
        chk(pc_q, 16'h1237);
    endtask

    initial
    begin
        {rstn, fetch, flow_load, flow_rel, inst_end, irq_req, alu_go, agen_go, agen_inc} = 9'h000;
        irq_vec = 16'hfff0;
        {flow_target, reg_imm, agen_off, rel_off, alu_b} = 64'h0;
        alu_op = ALU_ADD;
        alu_dst = DST_A;
        reg_op = ROP_NONE;
        agen_mode = AM_DIR;
        err_count = 0;
        checked = 0;
        rst;
        // flag results of adds, then a decimal correction
        op(7'h02, ROP_NONE, 16'h0078, ALU_PASS);
        op(7'h02, ROP_NONE, 16'h0008);
        chk(ccr_q, 16'h00fc);
        chk({signed_lt, signed_gt}, 16'h0001);
        op(7'h02, ROP_NONE, 16'h0080);
        chk(ccr_q, 16'h00eb);
        chk({signed_lt, signed_gt}, 16'h0002);
        op(7'h02, ROP_NONE, 16'h0009, ALU_PASS);
        op(7'h02, ROP_NONE, 16'h0009);
        op(7'h02, ROP_NONE, 16'h0000, ALU_DAA);
        chk(acc_q, 16'h0018);
        // index pair and effective addresses
        op(7'h00, ROP_LD_HX, 16'h8000);
        chk(hx_q, 16'h8000);
        chk(ccr_q[2:1], 16'h0002);
        op(7'h01, ROP_NONE, 16'h0005, ALU_ADD, AM_IX1);
        chk(ea_q, 16'h8005);
        op(7'h01, ROP_NONE, 16'hab12);
        chk(ea_q, 16'h0012);
        op(7'h00, ROP_TAX, 16'h0000);
        // post-increment addresses with the old pair; a compare discards its result
        op(7'h01, ROP_NONE, 16'h0000, ALU_ADD, AM_IX, 1'b1);
        chk(ea_q, 16'h8018);
        chk(hx_q, 16'h8019);
        op(7'h02, ROP_NONE, 16'h0018, ALU_SUB, AM_DIR, 1'b0, DST_NONE);
        chk({acc_q, ccr_q}, 16'h187a);
        // program counter: fetch, backward branch, jump
        op(7'h20, ROP_NONE, 16'h0000);
        chk(pc_q, 16'h1238);
        op(7'h08, ROP_NONE, 16'h00fe);
        chk(pc_q, 16'h1236);
        op(7'h10, ROP_NONE, 16'h4000);
        chk(pc_q, 16'h4000);
        // stack pointer arithmetic
        op(7'h00, ROP_AIS, 16'h007f);
        chk(sp_q, 16'h017e);
        op(7'h00, ROP_RSP, 16'h0000);
        chk(sp_q, 16'h01ff);
        op(7'h00, ROP_AIS, 16'h0080);
        chk(sp_q, 16'h017f);
        // masked, shadowed, then taken interrupt
        op(7'h44, ROP_NONE, 16'h0000);
        chk(busy, 16'h0000);
        op(7'h40, ROP_CLI, 16'h0000);
        op(7'h44, ROP_NONE, 16'h0000);
        chk(busy, 16'h0000);
        op(7'h44, ROP_NONE, 16'h0000);
        chk(busy, 16'h0001);
        idle;
        chk(sp_q, 16'h017a);
        chk(pc_q, 16'h567b);
        chk(ccr_q[3], 16'h0001);
        chk({pm.m[16'h017f], pm.m[16'h017e]}, 16'h0040);
        chk({pm.m[16'h017d], pm.m[16'h017c]}, 16'h1918);
        chk(pm.m[16'h017b] & 8'h68, 16'h0060);
        op(7'h00, ROP_NONE, 16'h0000);
        // second reset keeps accumulator and low index byte
        rst;
        chk(acc_q, 16'h0018);
        chk(hx_q, 16'h0019);
        summarize;
    end

    // hang guard, well above the expected run of some 100 cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            summarize;
        end
    end
endmodule
`default_nettype wire
